/* src/prio_pkg.sv */
/*
 * Constants, register map and configuration layouts of the relay I/O module.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
package prio_pkg;

  // ****************************************
  // Dimensions
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int NUM_EVT = 16;
  localparam int DLY_W = 14;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC_DEF = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int ZERO_DLY_MS = 300;
  localparam logic [DLY_W-1:0] ZERO_DLY_TICKS = DLY_W'(ZERO_DLY_MS / TICK_MS + 1);
  localparam int MIN_ACT1_MS = 100;
  localparam int MIN_ACT2_MS = 200;
  localparam logic [DLY_W-1:0] MIN_ACT1_TICKS = DLY_W'(MIN_ACT1_MS / TICK_MS);
  localparam logic [DLY_W-1:0] MIN_ACT2_TICKS = DLY_W'(MIN_ACT2_MS / TICK_MS);
  localparam int PULSE_MS_DEF = 1000;
  localparam logic [DLY_W-1:0] DLY_MAX_TICKS = 14'h2710;
  localparam logic [DLY_W-1:0] IN_DLY_RST = 14'h000A;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENTS = 8'h08;
  localparam logic [7:0] OFS_IN_EVT = 8'h0C;
  localparam logic [7:0] OFS_OUT_CFG = 8'h10;
  localparam logic [7:0] OFS_OUT_DLY = 8'h20;
  localparam logic [7:0] OFS_IN_CFG = 8'h30;

  // ****************************************
  // Control bits
  // ****************************************
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SELF_TEST = 1;
  localparam int CTRL_SIG_RESET = 2;
  localparam int CTRL_PWR_CTRL = 3;

  // ****************************************
  // Configuration layouts
  // ****************************************
  typedef struct packed {
    logic pulse;
    logic [1:0] min_sel;
    logic latch;
    logic nc;
    logic [NUM_EVT-1:0] mask;
  } prio_out_cfg_t;

  typedef struct packed {
    logic edge_fall;
    logic edge_rise;
    logic pol_open;
    logic [DLY_W-1:0] dly;
  } prio_in_cfg_t;

  localparam prio_out_cfg_t OUT_CFG_RST = '0;
  localparam prio_in_cfg_t IN_CFG_RST = '{edge_fall: 1'b0, edge_rise: 1'b0,
                                          pol_open: 1'b0, dly: IN_DLY_RST};

endpackage : prio_pkg

/* src/prio_qual.sv */
/*
 * Persistence qualifier: follows its raw level once a change has lasted
 * a given number of ticks; with RISE_ONLY a fall is followed on the next clock.
 * Assumes tick is a one-cycle pulse.
 */
`timescale 1ns/10ps
module prio_qual
  import prio_pkg::*;
#(
  parameter bit RISE_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic tick,
  input wire logic raw,
  input wire logic [DLY_W-1:0] limit,
  output logic q
);

  // ****************************************
  // Persistence counter
  // ****************************************
  logic [DLY_W-1:0] cnt_r;
  logic q_r;

  assign q = q_r;

  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      cnt_r <= '0;
      q_r <= 1'b0;
    end else if (raw == q_r) begin
      cnt_r <= '0;
    end else if (RISE_ONLY && !raw) begin
      q_r <= 1'b0;
      cnt_r <= '0;
    end else if (tick) begin
      if (cnt_r + 14'h0001 >= limit) begin
        q_r <= raw;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 14'h0001;
      end
    end
  end

endmodule : prio_qual

/* src/prio_top.sv */
/*
 * Relay I/O module: four qualified contact inputs, four programmable relay
 * outputs, indicator drive and an APB register slave.
 * Assumes pin inputs synchronous to clk_sys; in_short high means short circuit.
 */
// The APB slave port and the register offsets were chosen for this implementation.
// Summary of operation
// R1: Four programmable relay outputs and four qualified inputs, each with indicator.
// R2: When inactive all contacts open and input states are flagged invalid.
// R3: Per-input polarity maps short or open to ON; closed-active by default.
// R4: Input change recognised after persisting the input delay, 0-100 s, default 0.1 s.
// R5: Zero input delay still needs the change to last over 300 ms.
// R6: Output activates only if its source lasts the output delay, default zero.
// R7: Zero output delay still needs the source present over 300 ms.
// R8: Rest state normally open or closed; activation flips the contact.
// R9: Latched outputs stay active after source ends; unlatched ones follow the source.
// R10: Latched outputs clear on switch-off, self-test or signal-reset command.
// R11: Unlatched outputs stay active at least the minimum time 0, 100 or 200 ms.
// R12: Output indicator lit while its contact is closed.
// R13: Input indicator lit while its input is short-circuited; the code lights it only while the module is active.
// R14: Controller issues signal-reset commands to clear latched outputs.
// R15: Pulse mode, power-control use only, holds output a fixed time.
// R16: Source is one event or an event combination; none by default.
// R17: Each input flags a chosen change of its qualified state.
// R18: Power indicator lit while the module is active.
// R19: Controller should disable latching on power-control outputs.
// R20: Timing counts a fixed 10 ms tick derived from the clock.
`timescale 1ns/10ps
module prio_top
  import prio_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter int PULSE_MS = PULSE_MS_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] in_short,
  output logic [NUM_CH-1:0] relay_close,
  output logic [NUM_CH-1:0] led_out,
  output logic [NUM_CH-1:0] led_in,
  output logic led_power
);

  localparam logic [DLY_W-1:0] PULSE_TICKS = DLY_W'(PULSE_MS / TICK_MS);
  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // ****************************************
  // Registers
  // ****************************************
  logic enable_r;
  logic pwr_ctrl_r;
  logic self_test_r;
  logic sig_reset_r;
  logic [NUM_EVT-1:0] events_r;
  prio_out_cfg_t out_cfg_r [NUM_CH];
  logic [DLY_W-1:0] out_dly_r [NUM_CH];
  prio_in_cfg_t in_cfg_r [NUM_CH];
  logic [2*NUM_CH-1:0] in_evt_r;
  logic [2*NUM_CH-1:0] in_evt_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [NUM_CH-1:0] relay_r;
  logic [NUM_CH-1:0] led_in_r;
  logic led_power_r;

  logic [NUM_CH-1:0] in_state;
  logic [NUM_CH-1:0] in_state_d_r;
  logic [NUM_CH-1:0] out_act;
  logic [NUM_CH-1:0] contact;

  logic wr_en;
  logic setup;
  logic [3:0] wsel;
  logic [1:0] wch;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite;
  assign wsel = paddr[7:4];
  assign wch = paddr[3:2];

  // ****************************************
  // Tick generator
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1; // [R20]
    end else begin
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
      tick_r <= 1'b0;
    end
  end

  // ****************************************
  // Control register and command pulses
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_r <= 1'b0;
      pwr_ctrl_r <= 1'b0;
      self_test_r <= 1'b0;
      sig_reset_r <= 1'b0;
    end else begin
      self_test_r <= 1'b0;
      sig_reset_r <= 1'b0;
      if (wr_en && paddr == OFS_CTRL) begin
        enable_r <= pwdata[CTRL_ENABLE];
        pwr_ctrl_r <= pwdata[CTRL_PWR_CTRL];
        self_test_r <= pwdata[CTRL_SELF_TEST];
        sig_reset_r <= pwdata[CTRL_SIG_RESET]; // [R14]
      end
    end
  end

  // ****************************************
  // Event vector from the trip unit
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      events_r <= '0;
    end else if (wr_en && paddr == OFS_EVENTS) begin
      events_r <= pwdata[NUM_EVT-1:0];
    end
  end

  // ****************************************
  // Channel configuration
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        out_cfg_r[i] <= OUT_CFG_RST; // [R8] [R9] [R11] [R16]
        out_dly_r[i] <= '0;
        in_cfg_r[i] <= IN_CFG_RST; // [R3] [R4]
      end
    end else if (wr_en) begin
      if (wsel == OFS_OUT_CFG[7:4]) begin
        out_cfg_r[wch] <= pwdata[$bits(prio_out_cfg_t)-1:0];
      end
      if (wsel == OFS_OUT_DLY[7:4]) begin
        out_dly_r[wch] <= (pwdata[DLY_W-1:0] > DLY_MAX_TICKS) ? DLY_MAX_TICKS
                                                             : pwdata[DLY_W-1:0];
      end
      if (wsel == OFS_IN_CFG[7:4]) begin
        in_cfg_r[wch].dly <= (pwdata[DLY_W-1:0] > DLY_MAX_TICKS) ? DLY_MAX_TICKS
                                                                : pwdata[DLY_W-1:0];
        in_cfg_r[wch].pol_open <= pwdata[16];
        in_cfg_r[wch].edge_rise <= pwdata[17];
        in_cfg_r[wch].edge_fall <= pwdata[18];
      end
    end
  end

  // ****************************************
  // Input channels
  // ****************************************
  logic [2*NUM_CH-1:0] in_evt_set;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_in
    logic [DLY_W-1:0] lim;
    logic raw;

    assign raw = in_short[g] ^ in_cfg_r[g].pol_open; // [R3]
    assign lim = (in_cfg_r[g].dly == '0) ? ZERO_DLY_TICKS : in_cfg_r[g].dly; // [R5]

    prio_qual #(.RISE_ONLY(1'b0)) u_qual (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(!enable_r),
      .tick(tick_r),
      .raw(raw),
      .limit(lim),
      .q(in_state[g]) // [R4]
    );

    assign in_evt_set[g] = in_cfg_r[g].edge_rise && in_state[g] && !in_state_d_r[g]; // [R17]
    assign in_evt_set[NUM_CH+g] = in_cfg_r[g].edge_fall && !in_state[g] && in_state_d_r[g];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_state_d_r <= '0;
    end else begin
      in_state_d_r <= in_state;
    end
  end

  always_comb begin
    in_evt_nxt = in_evt_r;
    if (wr_en && paddr == OFS_IN_EVT) begin
      in_evt_nxt = in_evt_nxt & ~pwdata[2*NUM_CH-1:0];
    end
    in_evt_nxt = in_evt_nxt | in_evt_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_evt_r <= '0;
    end else begin
      in_evt_r <= in_evt_nxt;
    end
  end

  // ****************************************
  // Output channels
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_out
    logic src;
    logic src_q;
    logic src_q_d_r;
    logic act_r;
    logic [DLY_W-1:0] hold_r;
    logic [DLY_W-1:0] lim;
    logic [DLY_W-1:0] min_ticks;
    logic pulse_on;
    logic rise;

    assign src = |(events_r & out_cfg_r[g].mask); // [R16]
    assign lim = (out_dly_r[g] == '0) ? ZERO_DLY_TICKS : out_dly_r[g]; // [R7]
    assign pulse_on = out_cfg_r[g].pulse && pwr_ctrl_r;
    assign rise = src_q && !src_q_d_r;

    always_comb begin
      case (out_cfg_r[g].min_sel)
        2'h1: min_ticks = MIN_ACT1_TICKS;
        2'h2: min_ticks = MIN_ACT2_TICKS;
        default: min_ticks = '0;
      endcase
    end

    prio_qual #(.RISE_ONLY(1'b1)) u_qual (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(!enable_r),
      .tick(tick_r),
      .raw(src),
      .limit(lim),
      .q(src_q) // [R6]
    );

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        src_q_d_r <= 1'b0;
      end else begin
        src_q_d_r <= src_q;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst || !enable_r) begin
        hold_r <= '0; // [R2]
      end else if (rise) begin
        hold_r <= pulse_on ? PULSE_TICKS : min_ticks; // [R11] [R15]
      end else if (tick_r && hold_r != '0) begin
        hold_r <= hold_r - 14'h0001;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (rst || !enable_r) begin
        act_r <= 1'b0; // [R10]
      end else if (pulse_on) begin
        act_r <= rise || (hold_r != '0 && !(tick_r && hold_r == 14'h0001)); // [R15]
      end else if (out_cfg_r[g].latch) begin
        if (self_test_r || sig_reset_r) begin
          act_r <= 1'b0; // [R10]
        end else if (src_q) begin
          act_r <= 1'b1; // [R9]
        end
      end else begin
        act_r <= src_q || rise || (hold_r != '0 && !(tick_r && hold_r == 14'h0001)); // [R9] [R11]
      end
    end

    assign out_act[g] = act_r;
    assign contact[g] = enable_r && (act_r ^ out_cfg_r[g].nc); // [R2] [R8]
  end

  // ****************************************
  // Pins and indicators
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      relay_r <= '0;
      led_in_r <= '0;
      led_power_r <= 1'b0;
    end else begin
      relay_r <= contact; // [R1] [R2]
      led_in_r <= enable_r ? in_short : '0; // [R13]
      led_power_r <= enable_r; // [R18]
    end
  end

  assign relay_close = relay_r;
  assign led_out = relay_r; // [R12]
  assign led_in = led_in_r;
  assign led_power = led_power_r;

  // ****************************************
  // APB read path
  // ****************************************
  logic [31:0] rd_mux;
  logic rd_err;

  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end else begin
      case (wsel)
        4'h0: begin
          case (wch)
            2'h0: rd_mux = {28'h0, pwr_ctrl_r, 2'h0, enable_r};
            2'h1: rd_mux = {15'h0, enable_r, relay_r, out_act, in_state, 3'h0, enable_r}; // [R2]
            2'h2: rd_mux = {16'h0, events_r};
            default: rd_mux = {24'h0, in_evt_r};
          endcase
        end
        4'h1: rd_mux = {11'h0, out_cfg_r[wch]};
        4'h2: rd_mux = {18'h0, out_dly_r[wch]};
        4'h3: rd_mux = {13'h0, in_cfg_r[wch].edge_fall, in_cfg_r[wch].edge_rise,
                        in_cfg_r[wch].pol_open, 2'h0, in_cfg_r[wch].dly};
        default: rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      if (setup) begin
        prdata_r <= pwrite ? 32'h0 : rd_mux;
        pslverr_r <= rd_err;
      end else begin
        prdata_r <= '0;
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : prio_top

/* test/prio_checker.sv */
/*
 * Port checker for the relay I/O module: APB timing, indicators, idle state.
 * Assumes it is bound to prio_top, synchronous active-high rst.
 */
`timescale 1ns/10ps
module prio_chk
  import prio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] in_short,
  input wire logic [NUM_CH-1:0] relay_close,
  input wire logic [NUM_CH-1:0] led_out,
  input wire logic [NUM_CH-1:0] led_in,
  input wire logic led_power
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence ctrl_wr;
    psel && penable && pready && pwrite && paddr == OFS_CTRL;
  endsequence

  a_apb_ready: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held past access");
  a_bad_addr: assert property (apb_setup ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_power_follow: assert property (ctrl_wr |-> ##2 led_power == $past(pwdata[0], 2))
    else $error("power indicator off enable");
  a_off_open: assert property (!led_power && $past(!led_power) |-> relay_close == 4'h0)
    else $error("contact closed while inactive");
  a_in_led_off: assert property (!led_power && $past(!led_power) |-> led_in == 4'h0)
    else $error("input light while inactive");
  a_in_led_copy: assert property (led_power && $past(led_power) |-> led_in == $past(in_short))
    else $error("input light off contact");
  a_led_out_eq: assert property (led_out == relay_close)
    else $error("output light off contact");
endmodule : prio_chk

/* test/prio_host.sv */
/*
 * Trip unit model: APB master issuing configuration and commands.
 * Assumes the slave raises pready; only the bench watchdog ends a hang.
 */
`timescale 1ns/10ps
module prio_host
  import prio_pkg::*;
(
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****************************************
  // Bus transfer
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (!pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : prio_host

/* test/prio_top_tb.sv */
/*
 * Self-checking bench of the relay I/O module with a 10-cycle tick.
 * Assumes prio_host as bus master and prio_chk bound to the design.
 */
`timescale 1ns/10ps
module prio_top_tb
  import prio_pkg::*;
();
  // ****************************************
  // Signals and helpers
  // ****************************************
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} prio_row_t;
  localparam prio_row_t ROWS [7] = '{'{OFS_CTRL, 32'h0, 1'b0}, '{OFS_STATUS, 32'h0, 1'b0},
    '{OFS_OUT_CFG, 32'h0, 1'b0}, '{OFS_OUT_DLY, 32'h0, 1'b0},
    '{OFS_IN_CFG, 32'h0000000A, 1'b0}, '{8'h02, 32'h0, 1'b1}, '{8'hFC, 32'h0, 1'b1}};
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, led_power;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] in_short, relay_close, led_out, led_in;
  int miscompares, tests_run;

  prio_host prio_host_inst (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  prio_top #(.TICK_CYC(10)) prio_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_short(in_short), .relay_close(relay_close),
    .led_out(led_out), .led_in(led_in), .led_power(led_power));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    prio_host_inst.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    prio_host_inst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [3:0] exp);
    @(negedge clk_sys);
    chk_reg({28'h0, exp}, {28'h0, relay_close});
  endtask : chk_pin
  task automatic stat(input logic [3:0] exp);
    logic [31:0] q;
    logic e;
    rd(OFS_STATUS, q, e);
    chk_reg({28'h0, exp}, {28'h0, q[7:4]});
  endtask : stat
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    stop_test;
  end
  initial begin : main
    logic [31:0] q;
    logic e;
    rst = 1'b1;
    in_short = 4'h0;
    miscompares = 0;
    tests_run = 0;
    cyc(3);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      rd(ROWS[i].a, q, e);
      chk_reg(ROWS[i].d, q);
      chk_reg({31'h0, ROWS[i].e}, {31'h0, e});
    end
    wr(OFS_IN_CFG + 8'h04, 32'h0001000A);
    wr(OFS_IN_CFG + 8'h08, 32'h0);
    wr(OFS_OUT_CFG, 32'h00000001);
    wr(OFS_OUT_CFG + 8'h04, 32'h00010002);
    wr(OFS_OUT_CFG + 8'h08, 32'h00020004);
    wr(OFS_OUT_DLY + 8'h08, 32'h5);
    wr(OFS_OUT_CFG + 8'h0C, 32'h00080008);
    wr(OFS_OUT_DLY + 8'h0C, 32'h1);
    wr(OFS_CTRL, 32'h1);
    in_short <= 4'h5;
    cyc(75);
    stat(4'h0);
    cyc(25);
    stat(4'h3);
    cyc(215);
    stat(4'h7);
    chk_pin(4'b0010);
    wr(OFS_EVENTS, 32'hC);
    cyc(22);
    wr(OFS_EVENTS, 32'h0);
    cyc(30);
    chk_pin(4'b1010);
    cyc(220);
    chk_pin(4'b0010);
    wr(OFS_EVENTS, 32'h7);
    cyc(200);
    chk_pin(4'b0110);
    cyc(150);
    chk_pin(4'b0101);
    wr(OFS_EVENTS, 32'h0);
    cyc(5);
    chk_pin(4'b0110);
    for (int i = 1; i < 3; i++) begin
      wr(OFS_CTRL, 32'h1 | (32'h1 << i));
      cyc(5);
      chk_pin(4'b0010);
      wr(OFS_EVENTS, 32'h4);
      cyc(60);
      wr(OFS_EVENTS, 32'h0);
      cyc(5);
      chk_pin(4'b0110);
    end
    wr(OFS_CTRL, 32'h9);
    wr(OFS_OUT_CFG + 8'h0C, 32'h00100008);
    wr(OFS_EVENTS, 32'h8);
    cyc(20);
    wr(OFS_EVENTS, 32'h0);
    cyc(300);
    chk_pin(4'b1110);
    rd(OFS_STATUS, q, e);
    chk_reg(32'h0001EC71, q);
    cyc(800);
    chk_pin(4'b0110);
    wr(OFS_IN_CFG, 32'h0004000A);
    in_short <= 4'h4;
    cyc(120);
    rd(OFS_IN_EVT, q, e);
    chk_reg(32'h00000010, q);
    wr(OFS_IN_EVT, 32'h00000010);
    rd(OFS_IN_EVT, q, e);
    chk_reg(32'h0, q);
    wr(OFS_CTRL, 32'h0);
    cyc(5);
    chk_pin(4'b0000);
    rd(OFS_STATUS, q, e);
    chk_reg(32'h0, q);
    stop_test;
  end
endmodule : prio_top_tb

bind prio_top prio_chk prio_chk_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .in_short(in_short), .relay_close(relay_close),
  .led_out(led_out), .led_in(led_in), .led_power(led_power));
